// ### rtl/lbc_bus_ctrl.sv
// Local bus cycle controller, processor end of the 64-bit bus
`timescale 1ns/100ps
`include "lbc_cfg.svh"

module lbc_bus_ctrl
  import lbc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Core request side
  input  wire logic                   reqValid,
  output logic                        reqReady,
  input  wire logic                   reqWrite,
  input  wire logic [`LBC_ADDR_W-1:0] reqAddr,
  input  wire logic [`LBC_BE_W-1:0]   reqByteEn,
  input  wire logic                   reqNextNear,
  input  wire logic                   reqPageTable,
  input  wire logic [`LBC_DATA_W-1:0] reqData,
  // Core read return
  output logic                        rdValid,
  output logic      [`LBC_DATA_W-1:0] rdData,
  // Local bus pins
  output logic                        addr_strobe_n,
  output logic      [`LBC_ADDR_W-1:0] addr_bus,
  output logic                        write_not_read,
  output logic                        next_near_n,
  output logic                        page_table_flag,
  output logic      [`LBC_BE_W-1:0]   byte_lane_en_n,
  input  wire logic                   xfer_ack_n,
  input  wire logic                   next_addr_req_n,
  input  wire logic [`LBC_DATA_W-1:0] data_in,
  output logic      [`LBC_DATA_W-1:0] data_out,
  output logic                        data_oe_n
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  lbc_state_t             state;        // Bus state
  lbc_state_t             next_state;   // State after this edge
  logic                   bufValid;     // Pending request present
  logic [`LBC_REQ_W-1:0]  bufData;      // Pending request bundle
  logic                   launch;       // Strobe issued at this edge
  logic                   ack;          // Head cycle acknowledged
  logic                   naNow;        // Grant sampled this clock
  logic                   naOk;         // Grant available
  logic                   naUsed;       // Grant consumed by a launch
  logic [1:0]             outCount;     // Cycles outstanding
  logic [1:0]             remain;       // Outstanding after ack
  logic                   naHeld;       // Remembered grant
  logic                   lastWrite;    // Latest launched was a write
  logic [1:0]             qWr;          // Queue fill index
  logic [1:0]             qRd;          // Queue head index
  logic [1:0]             next_qRd;     // Head index after this edge
  logic                   qKind [`LBC_QDEP];  // Write flag per cycle
  logic [`LBC_DATA_W-1:0] qData [`LBC_QDEP];  // Write data per cycle
  logic                   next_oe;      // Data bus driven next clock
  logic [`LBC_DATA_W-1:0] next_dout;    // Data bus value next clock

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Queue index step with wrap at three
  function automatic logic [1:0] qStep(input logic [1:0] p);
    qStep = (p == `LBC_QLAST) ? `LBC_IDX_0 : p + `LBC_IDX_1;
  endfunction

  // --------------------------------------------------------------------
  // Request buffer
  // --------------------------------------------------------------------

  // Holds core requests until launched; full buffer stalls the core
  lbc_req_buf #(
    .WIDTH (`LBC_REQ_W),
    .DEPTH (`LBC_BUF_DEP)
  ) u_req_buf (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   ({reqWrite, reqNextNear, reqPageTable, reqAddr, reqByteEn,
                reqData}),
    .outValid (bufValid),
    .outReady (launch),
    .outData  (bufData)
  );

  // --------------------------------------------------------------------
  // Outstanding tracking
  // --------------------------------------------------------------------

  lbc_out_track u_out_track (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .launch   (launch),
    .ack      (ack),
    .naSeen   (naNow && !naUsed),
    .naUsed   (naUsed),
    .outCount (outCount),
    .naHeld   (naHeld)
  );

  // --------------------------------------------------------------------
  // Cycle decisions
  // --------------------------------------------------------------------

  // Acknowledge counts only for a cycle past its strobe clock
  assign ack = (state != LBC_IDLE)
               && (state != LBC_ADDR || outCount > `LBC_CNT_1)
               && !xfer_ack_n;
  assign remain = outCount - 2'(ack);

  // Grant ignored in a strobe clock and with nothing outstanding
  assign naNow = !next_addr_req_n && (state != LBC_ADDR)
                 && (outCount != `LBC_CNT_0);
  assign naOk  = naHeld || naNow;

  // Start when idle-after-ack, or overlapped under a grant below three
  assign launch = bufValid && (state != LBC_ADDR)
                  && ((remain == `LBC_CNT_0)
                      || (naOk && outCount != `LBC_MAX_OUT));
  assign naUsed = launch && (remain != `LBC_CNT_0);

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      LBC_IDLE: begin
        // Wait for a pending request
        next_state = launch ? LBC_ADDR : LBC_IDLE;
      end
      LBC_ADDR: begin
        // Strobe clock is always followed by a data clock
        next_state = LBC_DATA;
      end
      LBC_DATA: begin
        // Wait, finish, or start the next cycle
        if (launch) begin
          next_state = LBC_ADDR;
        end else if (remain == `LBC_CNT_0) begin
          next_state = LBC_IDLE;
        end else begin
          next_state = LBC_DATA;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= LBC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // Address and control pins
  // --------------------------------------------------------------------

  // Strobe for one clock per launch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_strobe_n <= 1'b1;
    end else begin
      addr_strobe_n <= !launch;
    end
  end

  // Cycle signals load at launch and hold through waits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_bus        <= `LBC_RST_ADDR;
      write_not_read  <= 1'b0;
      next_near_n     <= 1'b1;
      page_table_flag <= 1'b0;
      byte_lane_en_n  <= `LBC_RST_BE_N;
    end else if (launch) begin
      addr_bus        <= bufData[`LBC_F_ADDR];
      write_not_read  <= bufData[`LBC_F_WRITE];
      next_near_n     <= !bufData[`LBC_F_NEAR];
      page_table_flag <= bufData[`LBC_F_PTB];
      byte_lane_en_n  <= ~bufData[`LBC_F_BE];
    end
  end

  // Kind of the latest launched cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lastWrite <= 1'b0;
    end else if (launch) begin
      lastWrite <= bufData[`LBC_F_WRITE];
    end
  end

  // --------------------------------------------------------------------
  // Outstanding cycle queue
  // --------------------------------------------------------------------

  // Record kind and write data of each launched cycle
  always_ff @(posedge clock) begin
    if (launch) begin
      qKind[qWr] <= bufData[`LBC_F_WRITE];
      qData[qWr] <= bufData[`LBC_F_DATA];
    end
  end

  assign next_qRd = ack ? qStep(qRd) : qRd;

  // Queue pointers advance on launch and acknowledge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      qWr <= `LBC_IDX_0;
      qRd <= `LBC_IDX_0;
    end else begin
      if (launch) begin
        qWr <= qStep(qWr);
      end
      qRd <= next_qRd;
    end
  end

  // --------------------------------------------------------------------
  // Data bus drive
  // --------------------------------------------------------------------

  // Drive only the head cycle's write data, in launch order
  always_comb begin
    next_oe   = 1'b0;
    next_dout = data_out;
    if (remain != `LBC_CNT_0) begin
      // Head is past its strobe clock: drive if it writes
      next_oe   = qKind[next_qRd];
      next_dout = qData[next_qRd];
    end else if (launch && bufData[`LBC_F_WRITE] && lastWrite) begin
      // Lone write after a write may drive in its strobe clock
      next_oe   = 1'b1;
      next_dout = bufData[`LBC_F_DATA];
    end else if (launch && bufData[`LBC_F_WRITE]) begin
      // Write after a read waits for its data clock
      next_oe   = 1'b0;
      next_dout = bufData[`LBC_F_DATA];
    end
  end

  // Data bus registers; enable is low while driving
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_oe_n <= 1'b1;
      data_out  <= `LBC_RST_DATA;
    end else begin
      data_oe_n <= !next_oe;
      data_out  <= next_dout;
    end
  end

  // --------------------------------------------------------------------
  // Read return
  // --------------------------------------------------------------------

  // Capture read data at the acknowledge of a read cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdValid <= 1'b0;
      rdData  <= `LBC_RST_DATA;
    end else begin
      rdValid <= ack && !qKind[qRd];
      if (ack && !qKind[qRd]) begin
        rdData <= data_in;
      end
    end
  end

endmodule // lbc_bus_ctrl

// ### rtl/lbc_cfg.svh
// Constants for the local bus cycle controller
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define LBC_ADDR_W   29
`define LBC_DATA_W   64
`define LBC_BE_W     8
`define LBC_REQ_W    104
`define LBC_BUF_DEP  2

// ----------------------------------------------------------------------
// Request bundle field positions
// ----------------------------------------------------------------------
`define LBC_F_DATA   63:0
`define LBC_F_BE     71:64
`define LBC_F_ADDR   100:72
`define LBC_F_PTB    101
`define LBC_F_NEAR   102
`define LBC_F_WRITE  103

// ----------------------------------------------------------------------
// Cycle tracking
// ----------------------------------------------------------------------
`define LBC_MAX_OUT  2'h3
`define LBC_QDEP     3
`define LBC_QLAST    2'h2
`define LBC_IDX_0    2'h0
`define LBC_IDX_1    2'h1
`define LBC_CNT_0    2'h0
`define LBC_CNT_1    2'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LBC_RST_ADDR {`LBC_ADDR_W{1'b0}}
`define LBC_RST_DATA {`LBC_DATA_W{1'b0}}
`define LBC_RST_BE_N 8'hFF

`endif

// ### rtl/lbc_pkg.sv
// Types for the local bus cycle controller
package lbc_pkg;

  // Bus controller states
  typedef enum logic [1:0] {
    LBC_IDLE,
    LBC_ADDR,
    LBC_DATA
  } lbc_state_t;

endpackage

// ### rtl/lbc_req_buf.sv
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "lbc_cfg.svh"

module lbc_req_buf #(
  parameter int WIDTH = `LBC_REQ_W,
  parameter int DEPTH = `LBC_BUF_DEP
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [PW-1:0]    wrPtr;         // Fill pointer
  logic [PW-1:0]    rdPtr;         // Drain pointer
  logic [PW:0]      fill;          // Entries held
  logic             push;          // Word accepted
  logic             pop;           // Word taken

  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outData = mem[rdPtr];

  // Pointer step with wrap
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers, fill level and registered flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      fill     <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= step(wrPtr);
      end
      if (pop) begin
        rdPtr <= step(rdPtr);
      end
      fill     <= fill + (PW+1)'(push) - (PW+1)'(pop);
      inReady  <= (fill + (PW+1)'(push) - (PW+1)'(pop)) != (PW+1)'(DEPTH);
      outValid <= (fill + (PW+1)'(push) - (PW+1)'(pop)) != '0;
    end
  end

endmodule // lbc_req_buf

// ### rtl/lbc_out_track.sv
// Outstanding cycle counter and next-address grant latch
`timescale 1ns/100ps
`include "lbc_cfg.svh"

module lbc_out_track (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       launch,
  input  wire logic       ack,
  input  wire logic       naSeen,
  input  wire logic       naUsed,
  output logic      [1:0] outCount,
  output logic            naHeld
);

  // Count of cycles started and not yet acknowledged
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outCount <= `LBC_CNT_0;
    end else begin
      outCount <= outCount + 2'(launch) - 2'(ack);
    end
  end

  // Remember a one-clock grant until used or the bus drains
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      naHeld <= 1'b0;
    end else if (naUsed) begin
      naHeld <= 1'b0;
    end else if (outCount - 2'(ack) == `LBC_CNT_0) begin
      // A grant seen as the bus drains lapses with it
      naHeld <= 1'b0;
    end else if (naSeen) begin
      naHeld <= 1'b1;
    end
  end

endmodule // lbc_out_track

// ### testbench/lbc_bus_ctrl_checker.sv
// Concurrent checks on the bus cycle controller ports
`timescale 1ns/100ps
`include "lbc_cfg.svh"
module lbc_bus_ctrl_checker (
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire logic                   reqValid,
  input wire logic                   reqReady,
  input wire logic                   rdValid,
  input wire logic [`LBC_DATA_W-1:0] rdData,
  input wire logic                   addr_strobe_n,
  input wire logic [`LBC_ADDR_W-1:0] addr_bus,
  input wire logic                   write_not_read,
  input wire logic                   xfer_ack_n,
  input wire logic                   next_addr_req_n,
  input wire logic [`LBC_DATA_W-1:0] data_in,
  input wire logic                   data_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // Tracking
  // ------------------------------------------------
  logic [1:0] outCnt;      // Cycles outstanding
  logic [1:0] next_outCnt; // Count after this edge
  logic       gSeen;       // Grant seen since last strobe
  logic       anyCyc;      // Some cycle already started
  logic [2:0] pend;        // Requests taken, not launched
  // An ack in a lone strobe clock retires nothing
  assign next_outCnt = outCnt + {1'b0, !addr_strobe_n}
    - {1'b0, !xfer_ack_n && outCnt != 2'h0};
  // Counters for cycles and requests
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outCnt <= 2'h0;
      anyCyc <= 1'b0;
      pend <= 3'h0;
    end else begin
      outCnt <= next_outCnt;
      anyCyc <= anyCyc || !addr_strobe_n;
      pend <= pend + {2'h0, reqValid && reqReady}
        - {2'h0, !addr_strobe_n};
    end
  end
  // Grant ignored in strobe clocks, dropped when bus drains
  always_ff @(posedge clock) begin
    if (sys_rst || !addr_strobe_n || next_outCnt == 2'h0) begin
      gSeen <= 1'b0;
    end else if (!next_addr_req_n) begin
      gSeen <= 1'b1;
    end
  end
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  a_strobe_single: assert property (!addr_strobe_n |=> addr_strobe_n)
    else $error("strobe in two clocks running");
  a_strobe_cause: assert property (!addr_strobe_n |-> pend != 3'h0)
    else $error("strobe without a request");
  a_max_out: assert property (!addr_strobe_n |->
    outCnt != 2'h3 || !xfer_ack_n)
    else $error("fourth cycle started");
  a_overlap_grant: assert property (!addr_strobe_n
    && outCnt != 2'h0 |-> gSeen)
    else $error("overlapped start without grant");
  a_first_len: assert property (!addr_strobe_n && outCnt == 2'h0
    |=> !rdValid)
    else $error("cycle shorter than two clocks");
  // Reset reloads the pins, so the edge after it is not a hold
  a_ctrl_hold: assert property (addr_strobe_n
    && !$past(sys_rst) |-> $stable(addr_bus) && $stable(write_not_read))
    else $error("controls moved between strobes");
  a_rd_capture: assert property (rdValid |->
    !$past(xfer_ack_n) && rdData == $past(data_in))
    else $error("read return without ack data");
  a_read_float: assert property (!data_oe_n && addr_strobe_n
    && outCnt == 2'h1 |-> write_not_read)
    else $error("data bus driven in a read");
  a_war_no_drive: assert property (anyCyc && !addr_strobe_n &&
    write_not_read && !$past(write_not_read) |-> data_oe_n)
    else $error("write after read drove in strobe clock");
endmodule // lbc_bus_ctrl_checker

bind lbc_bus_ctrl lbc_bus_ctrl_checker u_chk (
  .clock, .sys_rst, .reqValid, .reqReady, .rdValid, .rdData,
  .addr_strobe_n, .addr_bus, .write_not_read, .xfer_ack_n,
  .next_addr_req_n, .data_in, .data_oe_n
);

// ### testbench/lbc_mem_model.sv
// Memory side model answering local bus cycles
`timescale 1ns/100ps
`include "lbc_cfg.svh"
module lbc_mem_model (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   addr_strobe_n,
  input  wire logic [`LBC_ADDR_W-1:0] addr_bus,
  input  wire logic                   write_not_read,
  input  wire logic [`LBC_BE_W-1:0]   byte_lane_en_n,
  input  wire logic [`LBC_DATA_W-1:0] data_out,
  input  wire logic                   data_oe_n,
  input  wire logic [1:0]             waits,
  input  wire logic                   grantOn,
  output logic                        xfer_ack_n,
  output logic                        next_addr_req_n,
  output logic      [`LBC_DATA_W-1:0] data_in,
  output logic                        pending,
  output int                          faults
);
  logic [12:0] q [$];     // Write flag, lanes, address
  logic [63:0] mem [16];  // Small word store
  logic [12:0] hd;        // Retired cycle
  logic        lastRd;    // Last retired was a read
  int          age;       // Clocks the head has waited
  initial begin
    xfer_ack_n = 1'b1;
    next_addr_req_n = 1'b1;
    data_in = 64'h0;
    pending = 1'b0;
    faults = 0;
    foreach (mem[i]) mem[i] = 64'h0;
  end
  // Retire the head on ack, queue every new strobe
  always @(posedge clock) begin
    if (sys_rst) begin
      q.delete();
      age = 0;
      lastRd = 1'b0;
    end else begin
      if (!xfer_ack_n && q.size() > 0) begin
        hd = q.pop_front();
        if (hd[12] && data_oe_n) faults++;
        for (int b = 0; b < 8; b++) begin
          if (hd[12] && !hd[4+b]) mem[hd[3:0]][8*b+:8] = data_out[8*b+:8];
        end
        lastRd = !hd[12];
        age = 0;
      end else if (q.size() > 0) age++;
      if (!addr_strobe_n) q.push_back({write_not_read, byte_lane_en_n,
        addr_bus[3:0]});
    end
    pending = q.size() > 0;
  end
  // Answer after the wait count, one more for write after read
  always @(negedge clock) begin
    if (q.size() > 0 && age >= int'(waits) +
        int'(q[0][12] && lastRd)) begin
      xfer_ack_n <= 1'b0;
      data_in <= q[0][12] ? ~data_in : mem[q[0][3:0]];
    end else begin
      xfer_ack_n <= 1'b1;
      data_in <= ~data_in;
    end
    next_addr_req_n <= !(grantOn && q.size() > 0);
  end
endmodule // lbc_mem_model

// ### testbench/local_bus_cycle_control_tb_top.sv
// Self-checking bench for the bus cycle controller
`timescale 1ns/100ps
`include "lbc_cfg.svh"
module local_bus_cycle_control_tb_top import lbc_pkg::*;;
  typedef struct {
    logic w;
    logic [`LBC_ADDR_W-1:0] a;
    logic [7:0] be;
    logic [63:0] d;
    logic [1:0] ws;
  } lbc_row_t;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqNextNear = 1'b0;
  logic reqPageTable = 1'b0;
  logic [`LBC_ADDR_W-1:0] reqAddr = 29'h0;
  logic [7:0] reqByteEn = 8'h0;
  logic [63:0] reqData = 64'h0;
  logic [1:0] waits = 2'h0;
  logic grantOn = 1'b0;
  logic reqReady, rdValid, addr_strobe_n, write_not_read, next_near_n;
  logic page_table_flag, xfer_ack_n, next_addr_req_n, data_oe_n, pending;
  logic [`LBC_ADDR_W-1:0] addr_bus;
  logic [7:0] byte_lane_en_n;
  logic [63:0] rdData, data_in, data_out;
  logic [63:0] shadow [16];  // Expected memory
  logic [63:0] expQ [$];     // Expected read returns
  logic prevRd = 1'b0;
  logic sawFull = 1'b0;
  int faults;
  int error_cnt = 0;
  int n_compared = 0;
  lbc_row_t rows [7] = '{
    '{1'b1, 29'h1, 8'hFF, 64'h0123456789ABCDEF, 2'h0},
    '{1'b0, 29'h1, 8'hFF, 64'h0, 2'h0},
    '{1'b1, 29'h1, 8'h0F, 64'hFEDCBA9876543210, 2'h1},
    '{1'b0, 29'h1, 8'hFF, 64'h0, 2'h2},
    '{1'b1, 29'h1FFFFFFF, 8'hF0, 64'hA5A5A5A55A5A5A5A, 2'h0},
    '{1'b1, 29'h1FFFFFFF, 8'h0F, 64'h3C3C3C3CC3C3C3C3, 2'h0},
    '{1'b0, 29'h1FFFFFFF, 8'hFF, 64'h0, 2'h3}};
  always #20 clock = ~clock;
  lbc_bus_ctrl dut (.clock, .sys_rst, .reqValid, .reqReady, .reqWrite,
    .reqAddr, .reqByteEn, .reqNextNear, .reqPageTable, .reqData, .rdValid,
    .rdData, .addr_strobe_n, .addr_bus, .write_not_read, .next_near_n,
    .page_table_flag, .byte_lane_en_n, .xfer_ack_n, .next_addr_req_n,
    .data_in, .data_out, .data_oe_n);
  lbc_mem_model mem (.clock, .sys_rst, .addr_strobe_n, .addr_bus,
    .write_not_read, .byte_lane_en_n, .data_out, .data_oe_n, .waits,
    .grantOn, .xfer_ack_n, .next_addr_req_n, .data_in, .pending, .faults);
  // ------------------------------------------------
  // Checking and closing
  // ------------------------------------------------
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task cmp_val(input logic [63:0] got, input logic [63:0] exp,
      input string w);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task cmp_flag(input logic got, input logic exp, input string w);
    cmp_val({63'h0, got}, {63'h0, exp}, w);
  endtask
  task time_out(input string w);
    error_cnt++;
    $display("ERROR %0t no progress in %s", $time, w);
    close_out();
  endtask
  // Read returns come back in launch order; watch for a full buffer
  always @(negedge clock) begin
    if (reqReady === 1'b0) sawFull = 1'b1;
    if (rdValid === 1'b1 && expQ.size() == 0) cmp_flag(1'b1, 1'b0, "stray");
    else if (rdValid === 1'b1) cmp_val(rdData, expQ.pop_front(), "rd");
  end
  // ------------------------------------------------
  // Stimulus tasks
  // ------------------------------------------------
  // Present one request and hold it until the edge that takes it
  task send(input logic w, input logic [28:0] a, input logic [7:0] be,
      input logic [63:0] d);
    int n;
    n = 0;
    reqWrite = w;
    reqAddr = a;
    reqByteEn = be;
    reqData = d;
    reqNextNear = a[0];
    reqPageTable = a[1];
    reqValid = 1'b1;
    while (!reqReady) begin
      @(negedge clock);
      if (++n > 50) time_out("request");
    end
    @(negedge clock);
    for (int b = 0; b < 8; b++) begin
      if (w && be[b]) shadow[a[3:0]][8*b+:8] = d[8*b+:8];
    end
    if (!w) expQ.push_back(shadow[a[3:0]]);
  endtask
  // Wait until the bus has been quiet for four clocks
  task settle;
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    while (quiet < 4) begin
      @(negedge clock);
      quiet = (pending || expQ.size() != 0 || !addr_strobe_n) ? 0 : quiet + 1;
      if (++n > 300) time_out("settle");
    end
  endtask
  // One lone cycle with its pins checked in the strobe and data clocks
  task op(input lbc_row_t r);
    int n;
    n = 0;
    waits = r.ws;
    send(r.w, r.a, r.be, r.d);
    reqValid = 1'b0;
    while (addr_strobe_n) begin
      @(negedge clock);
      if (++n > 10) time_out("strobe");
    end
    cmp_val({35'h0, addr_bus}, {35'h0, r.a}, "addr");
    cmp_flag(write_not_read, r.w, "dir");
    cmp_flag(next_near_n, !r.a[0], "near");
    cmp_flag(page_table_flag, r.a[1], "ptb");
    if (r.w) cmp_val({56'h0, byte_lane_en_n}, {56'h0, ~r.be}, "be");
    if (r.w && prevRd) cmp_flag(data_oe_n, 1'b1, "early");
    @(negedge clock);
    cmp_flag(data_oe_n, !r.w, "oe");
    if (r.w) cmp_val(data_out, r.d, "wdata");
    prevRd = !r.w;
    settle();
  endtask
  // Idle pin values during reset
  task chk_rst;
    cmp_flag(addr_strobe_n, 1'b1, "rst ads");
    cmp_flag(data_oe_n, 1'b1, "rst oe");
    cmp_val({56'h0, byte_lane_en_n}, 64'hFF, "rst be");
    cmp_val({35'h0, addr_bus}, 64'h0, "rst addr");
    cmp_flag(reqReady, 1'b1, "rst ready");
    cmp_flag(rdValid, 1'b0, "rst rd");
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    foreach (shadow[i]) shadow[i] = 64'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk_rst();
    sys_rst = 1'b0;
    foreach (rows[i]) op(rows[i]);
    $display("test rows done");
    // Back to back with grants: overlap up to three, write among reads
    waits = 2'h3;
    grantOn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      send(i == 3, 29'(i % 3), 8'hFF, 64'hC3C3C3C3C3C3C3C3 ^ i);
    end
    reqValid = 1'b0;
    settle();
    $display("test pipeline done");
    // No grants and slow memory: buffer fills, lanes merge in order
    grantOn = 1'b0;
    sawFull = 1'b0;
    for (int i = 0; i < 4; i++) send(1'b1, 29'h5, 8'h1 << i, 64'h1 << 9 * i);
    send(1'b0, 29'h5, 8'hFF, 64'h0);
    reqValid = 1'b0;
    settle();
    cmp_flag(sawFull, 1'b1, "full");
    $display("test refusal done");
    // Reset in a wait state, then a request at the first edge after it
    send(1'b0, 29'h2, 8'hFF, 64'h0);
    reqValid = 1'b0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b1;
    expQ.delete();
    @(negedge clock);
    chk_rst();
    sys_rst = 1'b0;
    prevRd = 1'b0;
    op(rows[1]);
    cmp_val(64'(faults), 64'h0, "undriven write");
    $display("test reset done");
    close_out();
  end
endmodule // local_bus_cycle_control_tb_top
